/* inc/cmc_pkg.sv */
package cmc_pkg;
	// Clock and time base
	localparam int          CLK_HZ        = 40_000_000;
	localparam int          TICK_US       = 1000;
	localparam int          TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
	localparam int          BOOST_DLY_MS  = 30;
	localparam int          BOOST_PFM_MS  = 2;
	localparam int          SAFETY_HR     = 10;
	localparam int          SAFETY_MS     = SAFETY_HR * 3600 * 1000;
	localparam int          WD_S          = 40;
	localparam int          WD_MS         = WD_S * 1000;
	localparam int          BLINK_MS      = 500;
	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_LIMIT     = 8'h04;
	localparam logic [7:0]  OFS_VREG      = 8'h08;
	localparam logic [7:0]  OFS_FAST_CHARGE_CURRENT      = 8'h0c;
	localparam logic [7:0]  OFS_ITERM     = 8'h10;
	localparam logic [7:0]  OFS_STATUS    = 8'h14;
	// Control register fields
	localparam int          B_CHG_EN      = 0;
	localparam int          B_BOOST_EN    = 1;
	localparam int          B_LLO         = 2;
	localparam int          B_BOOST_SEL   = 3;
	localparam int          B_FORCE_DET   = 4;
	localparam int          B_WD_KICK     = 5;
	localparam int          B_WD_LO       = 6;
	localparam int          B_TRK_LO      = 8;
	localparam int          B_IND_LO      = 10;
	localparam int          B_SW_OFF      = 12;
	localparam int          B_SW_RST_EN   = 13;
	localparam int          B_SW_DLY      = 14;
	localparam int          B_RECHG       = 15;
	// Reset values (limits in 100 mA steps, voltages in mV, currents mA)
	localparam logic [15:0] CTRL_RST      = 16'h2041;
	localparam logic [4:0]  ILIM_RST      = 5'h05;
	localparam logic [12:0] VLIM_RST      = 13'h1194;
	localparam logic [12:0] VREG_RST      = 13'h1070;
	localparam logic [11:0] FAST_CHARGE_CURRENT_RST      = 12'h800;
	localparam logic [7:0]  IPRE_RST      = 8'hb4;
	localparam logic [7:0]  ITERM_RST     = 8'hb4;
	localparam logic [11:0] ISHORT        = 12'h064;
	// Source detection
	localparam logic [4:0]  ILIM_USB      = 5'h05;
	localparam logic [4:0]  ILIM_ADAPTER  = 5'h18;
	localparam logic [4:0]  ILIM_SOFT     = 5'h02;
	localparam logic [4:0]  ILIM_PFM_MIN  = 5'h05;
	localparam logic [2:0]  TYPE_NONE     = 3'h0;
	localparam logic [2:0]  TYPE_USB      = 3'h1;
	localparam logic [2:0]  TYPE_ADAPTER  = 3'h3;
	localparam logic [2:0]  TYPE_BOOST    = 3'h7;
	// Voltage thresholds in mV
	localparam logic [12:0] VSYS_SOFT     = 13'h0898;
	localparam logic [12:0] VBAT_SHORT    = 13'h0898;
	localparam logic [12:0] VBAT_PRE      = 13'h0bb8;
	localparam logic [12:0] RECHG_LO      = 13'h0064;
	localparam logic [12:0] RECHG_HI      = 13'h00c8;
	localparam logic [12:0] TRK_200       = 13'h00c8;
	localparam logic [12:0] TRK_250       = 13'h00fa;
	localparam logic [12:0] TRK_300       = 13'h012c;
	// Charge phase, indicator and watchdog codes
	localparam logic [1:0]  PH_OFF        = 2'h0;
	localparam logic [1:0]  PH_PRE        = 2'h1;
	localparam logic [1:0]  PH_FAST       = 2'h2;
	localparam logic [1:0]  PH_DONE       = 2'h3;
	localparam logic [1:0]  IND_OFF       = 2'h3;
	localparam logic [1:0]  WD_DIS        = 2'h0;

	typedef enum logic [2:0] {
		SRC_IDLE = 3'b001,
		SRC_DET  = 3'b010,
		SRC_RUN  = 3'b100
	} cmc_src_t;

	typedef enum logic [3:0] {
		CHG_IDLE  = 4'b0001,
		CHG_RUN   = 4'b0010,
		CHG_DONE  = 4'b0100,
		CHG_FAULT = 4'b1000
	} cmc_chg_t;
endpackage

/* design/cmc_top.sv */
module cmc_top
	import cmc_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int SAFETY_TICKS = SAFETY_MS,
	parameter int WD_TICKS = WD_MS,
	parameter int BOOST_TICKS = BOOST_DLY_MS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        src_sel_pin,
	input  wire logic        chg_en_n_pin,
	input  wire logic        input_good,
	input  wire logic        bias_ok,
	input  wire logic [12:0] vbat_mv,
	input  wire logic [12:0] vsys_mv,
	input  wire logic [11:0] fast_charge_current_meas_ma,
	input  wire logic        reg_active,
	input  wire logic        therm_fault,
	input  wire logic        therm_boost_ok,
	input  wire logic        bat_above_min,
	input  wire logic        vbus_below_sleep,
	output logic             host_alert,
	output logic             conv_en_ff,
	output logic             bat_sw_on_ff,
	output logic      [4:0]  ilim_eff_ff,
	output logic      [12:0] vlim_eff_ff,
	output logic             pfm_en_ff,
	output logic             boost_on_ff,
	output logic             boost_pwm_ff,
	output logic             boost_ilim_ff,
	output logic      [12:0] vreg_out_ff,
	output logic      [11:0] fast_charge_current_out_ff,
	output logic             stat_pin_o,
	output logic             stat_pin_oe
);
	logic [1:0]  sel_sync_ff, cen_sync_ff;
	logic        sel_pin, chg_pin_ok;
	logic [15:0] ctrl_ff;
	logic [4:0]  ilim_ff;
	logic [12:0] vlim_ff, vreg_ff;
	logic [11:0] fast_charge_current_ff;
	logic [7:0]  ipre_ff, iterm_ff;
	logic        host_ff, wd_fault;
	logic [31:0] tick_cnt_ff, wd_cnt_ff, safe_cnt_ff, boost_cnt_ff;
	logic [31:0] blink_cnt_ff;
	logic        tick, wd_expire, wr, rd, kick, force_det;
	logic        pg_ff, blink_ff, safety_fault_ff, chg_enabled, chg_en_d_ff;
	logic [2:0]  type_ff;
	logic        det_alert, done_alert, start_ok, term_ok, rechg_ok;
	logic [12:0] rechg_mv, trk_mv, trk_sum;
	logic [4:0]  det_ilim;
	logic [2:0]  det_type;
	logic [1:0]  phase;
	logic        boost_cond;
	logic [31:0] wd_limit;
	cmc_src_t    src_ff, nxt_src;
	cmc_chg_t    chg_ff, nxt_chg;

	// Pins cross into pclk through two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_sync_ff <= 2'h0;
			cen_sync_ff <= 2'h3;
		end else begin
			sel_sync_ff <= {sel_sync_ff[0], src_sel_pin};
			cen_sync_ff <= {cen_sync_ff[0], chg_en_n_pin};
		end
	end
	assign sel_pin    = sel_sync_ff[1];
	assign chg_pin_ok = !cen_sync_ff[1];

	// APB: zero wait states, error on unmapped offsets
	assign pready    = 1'b1;
	assign wr        = psel && penable && pwrite;
	assign rd        = psel && penable && !pwrite;
	assign kick      = wr && paddr == OFS_CTRL && pwdata[B_WD_KICK];
	assign force_det = wr && paddr == OFS_CTRL && pwdata[B_FORCE_DET];
	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			case (paddr)
			OFS_CTRL, OFS_LIMIT, OFS_VREG, OFS_FAST_CHARGE_CURRENT, OFS_ITERM,
			OFS_STATUS: pslverr = 1'b0;
			default: pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
			OFS_CTRL:   prdata <= {16'h0, ctrl_ff};
			OFS_LIMIT:  prdata <= {11'h0, vlim_ff, 3'h0, ilim_ff};
			OFS_VREG:   prdata <= {19'h0, vreg_ff};
			OFS_FAST_CHARGE_CURRENT:   prdata <= {20'h0, fast_charge_current_ff};
			OFS_ITERM:  prdata <= {16'h0, iterm_ff, ipre_ff};
			OFS_STATUS: prdata <= {vlim_eff_ff, 2'h0, ilim_eff_ff,
				bat_sw_on_ff, conv_en_ff, pfm_en_ff, boost_on_ff,
				safety_fault_ff, wd_fault, phase, pg_ff, type_ff};
			default:    prdata <= 32'h0;
			endcase
		end
	end

	// Millisecond time base shared by all long timers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_ff <= 32'h0;
		end else if (tick) begin
			tick_cnt_ff <= 32'h0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h1;
		end
	end
	assign tick = tick_cnt_ff == 32'(TICK_CYCLES - 1);

	// Watchdog and host/default mode
	always_comb begin
		case (ctrl_ff[B_WD_LO +: 2])
		2'h1:    wd_limit = 32'(WD_TICKS);
		2'h2:    wd_limit = 32'(WD_TICKS * 2);
		default: wd_limit = 32'(WD_TICKS * 4);
		endcase
	end
	assign wd_expire = host_ff && !kick && ctrl_ff[B_WD_LO +: 2] != WD_DIS
		&& tick && wd_cnt_ff >= wd_limit - 32'h1;
	assign wd_fault = !host_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_ff   <= 1'b0;
			wd_cnt_ff <= 32'h0;
		end else if (kick) begin
			host_ff   <= 1'b1;
			wd_cnt_ff <= 32'h0;
		end else if (wd_expire) begin
			host_ff   <= 1'b0;
			wd_cnt_ff <= 32'h0;
		end else if (host_ff && tick) begin
			wd_cnt_ff <= wd_cnt_ff + 32'h1;
		end
	end

	// Kick wins over a simultaneous expiry, so a late kick is not lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff  <= CTRL_RST;
			vreg_ff  <= VREG_RST;
			fast_charge_current_ff  <= FAST_CHARGE_CURRENT_RST;
			ipre_ff  <= IPRE_RST;
			iterm_ff <= ITERM_RST;
		end else if (wd_expire) begin
			ctrl_ff  <= (CTRL_RST & ~16'((1 << B_SW_OFF) |
				(1 << B_SW_RST_EN) | (1 << B_SW_DLY))) | (ctrl_ff &
				16'((1 << B_SW_OFF) | (1 << B_SW_RST_EN) |
				(1 << B_SW_DLY)));
			vreg_ff  <= VREG_RST;
			fast_charge_current_ff  <= FAST_CHARGE_CURRENT_RST;
			ipre_ff  <= IPRE_RST;
			iterm_ff <= ITERM_RST;
		end else if (wr) begin
			case (paddr)
			OFS_CTRL:  ctrl_ff  <= pwdata[15:0] &
				~16'((1 << B_WD_KICK) | (1 << B_FORCE_DET));
			OFS_VREG:  vreg_ff  <= pwdata[12:0];
			OFS_FAST_CHARGE_CURRENT:  fast_charge_current_ff  <= pwdata[11:0];
			OFS_ITERM: begin
				ipre_ff  <= pwdata[7:0];
				iterm_ff <= pwdata[15:8];
			end
			default: ;
			endcase
		end
	end

	// Source type detection
	assign det_ilim = sel_pin ? ILIM_USB : ILIM_ADAPTER;
	assign det_type = sel_pin ? TYPE_USB : TYPE_ADAPTER;
	assign det_alert = src_ff == SRC_DET;

	always_comb begin
		nxt_src = src_ff;
		case (src_ff)
		SRC_IDLE: if (input_good && bias_ok) nxt_src = SRC_DET;
		SRC_DET:  nxt_src = SRC_RUN;
		SRC_RUN:  if (!input_good || !bias_ok) nxt_src = SRC_IDLE;
		default:  nxt_src = SRC_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_ff <= SRC_IDLE;
		end else begin
			src_ff <= nxt_src;
		end
	end

	// Host writes to the limit word take priority over pin reloads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ilim_ff <= ILIM_RST;
			vlim_ff <= VLIM_RST;
		end else if (wr && paddr == OFS_LIMIT) begin
			ilim_ff <= pwdata[4:0];
			vlim_ff <= pwdata[20:8];
		end else if (src_ff == SRC_DET) begin
			ilim_ff <= det_ilim;
		end else if (src_ff == SRC_RUN && (host_ff ? force_det : 1'b1)) begin
			ilim_ff <= det_ilim;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pg_ff   <= 1'b0;
			type_ff <= TYPE_NONE;
		end else if (boost_on_ff) begin
			pg_ff   <= 1'b0;
			type_ff <= TYPE_BOOST;
		end else if (src_ff == SRC_DET) begin
			pg_ff   <= 1'b1;
			type_ff <= det_type;
		end else if (src_ff == SRC_RUN) begin
			if (!host_ff || force_det) begin
				type_ff <= det_type;
			end
		end else begin
			pg_ff   <= 1'b0;
			type_ff <= TYPE_NONE;
		end
	end

	// Converter limits and light-load mode
	always_comb begin
		case (ctrl_ff[B_TRK_LO +: 2])
		2'h1:    trk_mv = TRK_200;
		2'h2:    trk_mv = TRK_250;
		default: trk_mv = TRK_300;
		endcase
	end
	assign trk_sum = vbat_mv + trk_mv;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_en_ff    <= 1'b0;
			bat_sw_on_ff  <= 1'b0;
			ilim_eff_ff   <= ILIM_SOFT;
			vlim_eff_ff   <= VLIM_RST;
			pfm_en_ff     <= 1'b0;
			boost_ilim_ff <= 1'b0;
		end else begin
			conv_en_ff   <= src_ff == SRC_RUN;
			bat_sw_on_ff <= chg_enabled && !ctrl_ff[B_SW_OFF]
				&& chg_ff != CHG_DONE;
			if (vsys_mv < VSYS_SOFT && ilim_ff > ILIM_SOFT) begin
				ilim_eff_ff <= ILIM_SOFT;
			end else begin
				ilim_eff_ff <= ilim_ff;
			end
			if (ctrl_ff[B_TRK_LO +: 2] != 2'h0 && trk_sum > vlim_ff) begin
				vlim_eff_ff <= trk_sum;
			end else begin
				vlim_eff_ff <= vlim_ff;
			end
			if (boost_on_ff) begin
				pfm_en_ff <= !boost_pwm_ff && !ctrl_ff[B_LLO];
			end else begin
				pfm_en_ff <= conv_en_ff && !ctrl_ff[B_LLO]
					&& ilim_ff >= ILIM_PFM_MIN;
			end
			boost_ilim_ff <= ctrl_ff[B_BOOST_SEL];
		end
	end

	// Boost qualification: delay restarts whenever a condition drops
	assign boost_cond = bat_above_min && vbus_below_sleep && therm_boost_ok
		&& ctrl_ff[B_BOOST_EN];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boost_cnt_ff <= 32'h0;
			boost_on_ff  <= 1'b0;
			boost_pwm_ff <= 1'b0;
		end else if (!boost_cond) begin
			boost_cnt_ff <= 32'h0;
			boost_on_ff  <= 1'b0;
			boost_pwm_ff <= 1'b0;
		end else if (tick) begin
			if (boost_cnt_ff != 32'(BOOST_TICKS + BOOST_PFM_MS)) begin
				boost_cnt_ff <= boost_cnt_ff + 32'h1;
			end
			if (boost_cnt_ff == 32'(BOOST_TICKS - 1)) begin
				boost_on_ff <= 1'b1;
			end
			if (boost_cnt_ff == 32'(BOOST_TICKS + BOOST_PFM_MS - 1)) begin
				boost_pwm_ff <= 1'b1;
			end
		end
	end

	// Charge cycle
	assign chg_enabled = ctrl_ff[B_CHG_EN] && chg_pin_ok;
	assign rechg_mv = ctrl_ff[B_RECHG] ? RECHG_HI : RECHG_LO;
	assign rechg_ok = vbat_mv > vreg_ff - rechg_mv;
	assign start_ok = conv_en_ff && chg_enabled && fast_charge_current_ff != 12'h0
		&& !therm_fault && !safety_fault_ff && !ctrl_ff[B_SW_OFF];
	assign term_ok = fast_charge_current_meas_ma < {4'h0, iterm_ff} && rechg_ok
		&& !reg_active;
	assign done_alert = chg_ff == CHG_RUN && nxt_chg == CHG_DONE;

	always_comb begin
		nxt_chg = chg_ff;
		case (chg_ff)
		CHG_IDLE: if (start_ok) nxt_chg = CHG_RUN;
		CHG_RUN: begin
			if (!chg_enabled || !conv_en_ff || ctrl_ff[B_SW_OFF]) begin
				nxt_chg = CHG_IDLE;
			end else if (therm_fault || safety_fault_ff) begin
				nxt_chg = CHG_FAULT;
			end else if (term_ok) begin
				nxt_chg = CHG_DONE;
			end
		end
		CHG_DONE: begin
			if (!chg_enabled) begin
				nxt_chg = CHG_IDLE;
			end else if (!rechg_ok) begin
				nxt_chg = CHG_RUN;
			end
		end
		CHG_FAULT: begin
			if (!chg_enabled) begin
				nxt_chg = CHG_IDLE;
			end else if (!therm_fault && !safety_fault_ff) begin
				nxt_chg = CHG_RUN;
			end
		end
		default: nxt_chg = CHG_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chg_ff <= CHG_IDLE;
		end else begin
			chg_ff <= nxt_chg;
		end
	end

	// Timer pauses in fault, clears only when charging is disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			safe_cnt_ff     <= 32'h0;
			safety_fault_ff <= 1'b0;
			chg_en_d_ff     <= 1'b0;
		end else begin
			chg_en_d_ff <= chg_enabled;
			if (!chg_enabled) begin
				safe_cnt_ff     <= 32'h0;
				safety_fault_ff <= 1'b0;
			end else if (chg_ff == CHG_RUN && tick) begin
				if (safe_cnt_ff == 32'(SAFETY_TICKS - 1)) begin
					safety_fault_ff <= 1'b1;
				end else begin
					safe_cnt_ff <= safe_cnt_ff + 32'h1;
				end
			end
		end
	end

	always_comb begin
		case (chg_ff)
		CHG_RUN:  phase = vbat_mv < VBAT_PRE ? PH_PRE : PH_FAST;
		CHG_DONE: phase = PH_DONE;
		default:  phase = PH_OFF;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vreg_out_ff <= VREG_RST;
			fast_charge_current_out_ff <= 12'h0;
		end else begin
			vreg_out_ff <= vreg_ff;
			if (chg_ff != CHG_RUN) begin
				fast_charge_current_out_ff <= 12'h0;
			end else if (vbat_mv < VBAT_SHORT) begin
				fast_charge_current_out_ff <= ISHORT;
			end else if (vbat_mv < VBAT_PRE) begin
				fast_charge_current_out_ff <= {4'h0, ipre_ff};
			end else begin
				fast_charge_current_out_ff <= fast_charge_current_ff;
			end
		end
	end

	// Indicator pin and alert
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_ff <= 32'h0;
			blink_ff     <= 1'b0;
		end else if (tick) begin
			if (blink_cnt_ff == 32'(BLINK_MS - 1)) begin
				blink_cnt_ff <= 32'h0;
				blink_ff     <= !blink_ff;
			end else begin
				blink_cnt_ff <= blink_cnt_ff + 32'h1;
			end
		end
	end
	assign stat_pin_o = chg_ff == CHG_FAULT ? blink_ff :
		chg_ff != CHG_RUN;
	assign stat_pin_oe = ctrl_ff[B_IND_LO +: 2] != IND_OFF;
	assign host_alert = det_alert || done_alert;

	det_alert_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		src_ff == SRC_IDLE && input_good && bias_ok |=> host_alert
		##1 (pg_ff && ilim_ff == $past(det_ilim)))
		else $error("detection did not alert and load");
	det_code_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(pg_ff) && !boost_on_ff |-> type_ff ==
		($past(sel_sync_ff[1]) ? TYPE_USB : TYPE_ADAPTER))
		else $error("wrong input type code");
	soft_lim_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		vsys_mv < VSYS_SOFT && $stable(vsys_mv)
		|=> ilim_eff_ff <= ILIM_SOFT)
		else $error("soft start cap missing");
	pfm_gate_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		pfm_en_ff |-> !$past(ctrl_ff[B_LLO])
		&& ($past(boost_on_ff) || $past(ilim_ff) >= ILIM_PFM_MIN))
		else $error("light load mode while inhibited");
	boost_qual_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(boost_on_ff) |-> $past(boost_cond) && type_ff != TYPE_BOOST
		##1 type_ff == TYPE_BOOST)
		else $error("boost start not qualified");
	wd_mode_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		kick |=> !wd_fault)
		else $error("kick did not enter host mode");
	wd_keep_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		wd_expire |=> !host_ff && fast_charge_current_ff == FAST_CHARGE_CURRENT_RST
		&& ilim_ff == $past(ilim_ff))
		else $error("expiry reset wrong registers");
	chg_start_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		chg_ff == CHG_IDLE ##1 chg_ff == CHG_RUN |-> $past(start_ok))
		else $error("cycle started without conditions");
	done_alert_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		chg_ff == CHG_RUN && nxt_chg == CHG_DONE |-> host_alert
		##1 phase == PH_DONE [*1] ##1 !bat_sw_on_ff)
		else $error("completion not reported");
	stat_drive_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		chg_ff == CHG_RUN |-> !stat_pin_o)
		else $error("indicator not low while charging");
endmodule

/* verif/cmc_phy_model.sv */
module cmc_phy_model (
	input  wire logic pclk,
	input  wire logic usb_host,
	input  wire logic chg_on,
	output logic      src_sel_pin,
	output logic      chg_en_n_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// One process owns both pins: idle levels, then edge-driven
	// Pins move just after an edge, like a real PHY output
	initial begin
		src_sel_pin = 1'b1;
		chg_en_n_pin = 1'b1;
		forever begin
			@(posedge pclk);
			src_sel_pin <= usb_host;
			chg_en_n_pin <= ~chg_on;
		end
	end
endmodule

/* verif/cmc_top_test.sv */
module cmc_top_test import cmc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        src_sel_pin, chg_en_n_pin, usb_host, chg_on, err;
	logic        input_good, bias_ok, reg_active, therm_fault;
	logic        therm_boost_ok, bat_above_min, vbus_below_sleep;
	logic        host_alert, conv_en_ff, bat_sw_on_ff, pfm_en_ff;
	logic        boost_on_ff, boost_pwm_ff, boost_ilim_ff;
	logic        stat_pin_o, stat_pin_oe;
	logic [12:0] vbat_mv, vsys_mv, vlim_eff_ff, vreg_out_ff;
	logic [11:0] fast_charge_current_meas_ma, fast_charge_current_out_ff;
	logic [4:0]  ilim_eff_ff;
	int          fails, n_checks, i;

	cmc_top #(.TICK_CYCLES(4), .SAFETY_TICKS(200), .WD_TICKS(5),
		.BOOST_TICKS(3)) dut_u (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.src_sel_pin, .chg_en_n_pin, .input_good, .bias_ok, .vbat_mv,
		.vsys_mv, .fast_charge_current_meas_ma, .reg_active, .therm_fault,
		.therm_boost_ok, .bat_above_min, .vbus_below_sleep, .host_alert,
		.conv_en_ff, .bat_sw_on_ff, .ilim_eff_ff, .vlim_eff_ff,
		.pfm_en_ff, .boost_on_ff, .boost_pwm_ff, .boost_ilim_ff,
		.vreg_out_ff, .fast_charge_current_out_ff, .stat_pin_o, .stat_pin_oe);
	cmc_phy_model phy_u (.pclk, .usb_host, .chg_on, .src_sel_pin,
		.chg_en_n_pin);

	always #12.5 pclk = ~pclk;

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task wait_alert;
		for (i = 0; i < 200 && host_alert !== 1'b1; i++) @(posedge pclk);
		chk(host_alert, 1'b1);
	endtask

	task t_reset;
		apb(0, OFS_CTRL, 0);
		chk(rd, 32'h2041);
		apb(0, OFS_LIMIT, 0);
		chk(rd, {11'h0, VLIM_RST, 3'h0, ILIM_RST});
		apb(0, OFS_VREG, 0);
		chk(rd, 32'h1070);
		chk(vreg_out_ff, 13'h1070);
		apb(0, OFS_FAST_CHARGE_CURRENT, 0);
		chk(rd, 32'h800);
		apb(0, OFS_ITERM, 0);
		chk(rd, 32'hb4b4);
		apb(0, OFS_STATUS, 0);
		chk(rd[6], 1'b1);
	endtask

	task t_detect;
		input_good <= 1'b1;
		bias_ok <= 1'b1;
		wait_alert;
		wait_cyc(3);
		chk(ilim_eff_ff, 5'h05);
		chk(conv_en_ff, 1'b1);
		apb(0, OFS_STATUS, 0);
		chk(rd[3:0], 4'h9);
		usb_host <= 1'b0;
		wait_cyc(6);
		chk(ilim_eff_ff, 5'h18);
		apb(0, OFS_STATUS, 0);
		chk(rd[2:0], 3'h3);
		vsys_mv <= 13'h0800;
		wait_cyc(3);
		chk(ilim_eff_ff, 5'h02);
		// Limit register is still 2.4 A, so light load stays allowed
		chk(pfm_en_ff, 1'b1);
		vsys_mv <= 13'h0bb8;
		wait_cyc(3);
		chk(pfm_en_ff, 1'b1);
	endtask

	task t_charge;
		apb(0, OFS_STATUS, 0);
		chk(rd[5:4], 2'h1);
		chk(fast_charge_current_out_ff, 12'h0b4);
		chk(stat_pin_o, 1'b0);
		chk(bat_sw_on_ff, 1'b1);
		vbat_mv <= 13'h0dac;
		wait_cyc(3);
		apb(0, OFS_STATUS, 0);
		chk(rd[5:4], 2'h2);
		chk(fast_charge_current_out_ff, 12'h800);
		vbat_mv <= 13'h1036;
		fast_charge_current_meas_ma <= 12'h064;
		wait_alert;
		wait_cyc(2);
		apb(0, OFS_STATUS, 0);
		chk(rd[5:4], 2'h3);
		chk(stat_pin_o, 1'b1);
		apb(1, OFS_CTRL, 32'h2c41);
		wait_cyc(2);
		chk(stat_pin_oe, 1'b0);
	endtask

	task t_wdog;
		apb(1, OFS_CTRL, 32'h6121);
		apb(1, OFS_LIMIT, {11'h0, 13'h11f8, 3'h0, 5'h04});
		vbat_mv <= 13'h1194;
		wait_cyc(60);
		apb(0, OFS_STATUS, 0);
		chk(rd[6], 1'b0);
		chk(vlim_eff_ff, 13'h125c);
		chk(pfm_en_ff, 1'b0);
		apb(1, OFS_LIMIT, {11'h0, 13'h11f8, 3'h0, 5'h05});
		wait_cyc(2);
		chk(pfm_en_ff, 1'b1);
		chk(ilim_eff_ff, 5'h05);
		apb(1, OFS_CTRL, 32'h6111);
		wait_cyc(2);
		chk(ilim_eff_ff, 5'h18);
		apb(1, OFS_CTRL, 32'h6161);
		wait_cyc(60);
		apb(0, OFS_STATUS, 0);
		chk(rd[6], 1'b1);
		apb(0, OFS_CTRL, 0);
		chk(rd, 32'h6041);
		apb(0, OFS_LIMIT, 0);
		chk(rd[20:8], 13'h11f8);
	endtask

	task t_boost;
		bat_above_min <= 1'b1;
		vbus_below_sleep <= 1'b1;
		therm_boost_ok <= 1'b1;
		apb(1, OFS_CTRL, 32'h604b);
		wait_cyc(6);
		chk(boost_on_ff, 1'b0);
		for (i = 0; i < 100 && boost_on_ff !== 1'b1; i++) @(posedge pclk);
		chk(boost_on_ff, 1'b1);
		chk(boost_pwm_ff, 1'b0);
		chk(boost_ilim_ff, 1'b1);
		apb(0, OFS_STATUS, 0);
		chk(rd[2:0], 3'h7);
		wait_cyc(12);
		chk(boost_pwm_ff, 1'b1);
		apb(0, 8'h20, 0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
	endtask

	task t_safety;
		logic lvl;
		vbat_mv <= 13'h0dac;
		wait_cyc(900);
		apb(0, OFS_STATUS, 0);
		chk(rd[7], 1'b1);
		chk(rd[10], 1'b1);
		chk(fast_charge_current_out_ff, 12'h0);
		lvl = stat_pin_o;
		for (i = 0; i < 2100 && stat_pin_o === lvl; i++) @(posedge pclk);
		chk(stat_pin_o, !lvl);
	endtask

	task close_out;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#150000;
		fails++;
		close_out;
	end

	initial begin
		{presetn, psel, penable, pwrite, input_good, bias_ok} = 0;
		{reg_active, therm_fault, therm_boost_ok} = 0;
		{bat_above_min, vbus_below_sleep} = 0;
		{paddr, pwdata} = 0;
		{usb_host, chg_on} = 2'b11;
		vbat_mv = 13'h09c4;
		vsys_mv = 13'h0bb8;
		fast_charge_current_meas_ma = 12'h400;
		// Short reset; first request follows the release edge
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_detect;
		t_charge;
		t_wdog;
		t_boost;
		t_safety;
		close_out;
	end
endmodule
